// ### core/src_pkg.sv
// constants and carrier types for the sleep and reset controller
package src_pkg;
  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_SLEEP_CTRL = 8'h00;
  localparam logic [7:0] OFF_PWR_RED = 8'h04;
  localparam logic [7:0] OFF_RST_STATUS = 8'h08;
  localparam logic [7:0] OFF_RST_CTRL = 8'h0C;
  localparam logic [7:0] OFF_INT_STATUS = 8'h10;
  localparam logic [7:0] OFF_INT_MASK = 8'h14;
  localparam logic [7:0] OFF_SLEEP_STATE = 8'h18;
  // ==========================================================
  // sleep control fields
  localparam int SC_MODE_LSB = 0;
  localparam int SC_MODE_W = 3;
  localparam int SC_RTC_EN = 3;
  localparam int SC_GO = 4;
  // sleep mode codes
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_PDOWN = 3'h1;
  localparam logic [2:0] MODE_PSAVE = 3'h2;
  localparam logic [2:0] MODE_STBY = 3'h3;
  localparam logic [2:0] MODE_XSTBY = 3'h4;
  localparam logic [2:0] MODE_RST = 3'h0;
  // ==========================================================
  // reset status flags and reset control bits
  localparam int RF_POR = 0;
  localparam int RF_EXT = 1;
  localparam int RF_WDT = 2;
  localparam int RF_BOD = 3;
  localparam int RF_W = 4;
  localparam int RC_WDT_EN = 0;
  localparam int RC_BOD_EN = 1;
  // ==========================================================
  // interrupt events
  localparam int EV_WAKE = 0;
  localparam int EV_SLEEP = 1;
  localparam int EV_W = 2;
  // ==========================================================
  // reset vector
  localparam int VEC_W = 16;
  localparam logic [15:0] RESET_VEC_DEF = 16'h0000;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic twi_match;
    logic port_async;
    logic rtc_irq;
  } async_wake_t;
  typedef struct packed {
    logic cpu;
    logic nvm;
    logic per;
    logic sys_src;
    logic rtc_src;
    logic rtc;
  } clk_en_t;
endpackage

// ### core/sleep_reset_ctrl.sv
// sleep mode sequencing, peripheral clock gating and system reset control
// Functional notes
// - five sleep modes, each entered from active on software request
// - asleep: allowed enabled interrupt or any enabled reset returns to active
// - power reduction bit stops that peripheral's clock, freezing its state
// - idle: cpu and nvm clocks off, peripherals run, any interrupt wakes
// - power-down: all system clock sources and rtc source stopped
// - power-down wakes only on two-wire address match or async port interrupt
// - power-save: as power-down, enabled rtc runs and its interrupt wakes
// - standby: as power-down but system clock sources kept running
// - reset returns registers to initial values, sram untouched
// - reset vector is address zero, or boot start when option set
// - pins go high impedance at once when any reset source asserts
// - reset asserts asynchronously, needing no running clock
// - cause of last reset readable in a status register
// - held in reset while power-on detector reports low supply
// - reset while external reset pin is low
// - watchdog expiry resets when enabled; watchdog has its own oscillator
// - enabled brown-out detector reporting low supply resets; disabled does nothing
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module sleep_reset_ctrl #(
  parameter int N_PER = 8,
  parameter logic [15:0] BOOT_ADDR = 16'h4000
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [src_pkg::ADDR_W-1:0] addr,
  input wire logic [src_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [src_pkg::DATA_W-1:0] rdata,
  input wire logic [N_PER-1:0] per_irq,
  input wire src_pkg::async_wake_t async_wake,
  input wire logic por_low,
  input wire logic ext_rst_n,
  input wire logic wdt_expire,
  input wire logic bod_low,
  input wire logic boot_vec_sel,
  output logic irq,
  output logic sys_rst,
  output logic pin_hiz,
  output src_pkg::clk_en_t clk_en,
  output logic [N_PER-1:0] per_clk_en,
  output logic [src_pkg::VEC_W-1:0] reset_vec
);
  // ==========================================================
  // state
  typedef enum logic [0:0] {ST_ACTIVE, ST_SLEEP} st_t;
  typedef struct packed {
    st_t st;
    logic [2:0] mode;
    logic rtc_en;
    logic [N_PER-1:0] pr;
    logic wdt_en;
    logic bod_en;
    logic [src_pkg::RF_W-1:0] rflags;
    logic [src_pkg::EV_W-1:0] ists;
    logic [src_pkg::EV_W-1:0] imask;
    logic [src_pkg::DATA_W-1:0] rdata;
    logic irq;
    src_pkg::clk_en_t clk_en;
    logic [N_PER-1:0] per_clk_en;
    logic [src_pkg::VEC_W-1:0] reset_vec;
  } state_t;
  state_t s_r;
  state_t s_nxt;
  logic sys_rst_r;
  logic pin_hiz_r;
  logic src_any;
  logic [src_pkg::RF_W-1:0] cause;
  logic ctl_rst;
  logic wake;
  logic sleep_req;
  // ==========================================================
  // reset sources
  always_comb begin
    cause = '0;
    cause[src_pkg::RF_POR] = por_low;
    cause[src_pkg::RF_EXT] = ~ext_rst_n;
    cause[src_pkg::RF_WDT] = wdt_expire & s_r.wdt_en;
    cause[src_pkg::RF_BOD] = bod_low & s_r.bod_en;
  end
  assign src_any = |cause;
  assign ctl_rst = rst | sys_rst_r;
  // async assertion, release on the clock
  always_ff @(posedge mclk or posedge src_any) begin
    if (src_any) begin
      sys_rst_r <= 1'b1;
      pin_hiz_r <= 1'b1;
    end else begin
      sys_rst_r <= rst;
      pin_hiz_r <= rst;
    end
  end
  // ==========================================================
  // wake qualification per mode
  always_comb begin
    wake = 1'b0;
    unique case (s_r.mode)
      src_pkg::MODE_IDLE: wake = (|per_irq) | (|async_wake);
      src_pkg::MODE_PDOWN, src_pkg::MODE_STBY: begin
        wake = async_wake.twi_match | async_wake.port_async;
      end
      src_pkg::MODE_PSAVE, src_pkg::MODE_XSTBY: begin
        wake = async_wake.twi_match | async_wake.port_async
          | (async_wake.rtc_irq & s_r.rtc_en);
      end
      default: wake = 1'b1;
    endcase
  end
  assign sleep_req = wr && addr == src_pkg::OFF_SLEEP_CTRL && wdata[src_pkg::SC_GO]
    && wdata[src_pkg::SC_MODE_LSB +: src_pkg::SC_MODE_W] <= src_pkg::MODE_XSTBY;
  // ==========================================================
  // next state
  always_comb begin
    logic [src_pkg::EV_W-1:0] ev;
    ev = '0;
    s_nxt = s_r;
    s_nxt.rdata = '0;
    // register writes
    if (wr) begin
      unique case (addr)
        src_pkg::OFF_SLEEP_CTRL: begin
          if (s_r.st == ST_ACTIVE) begin
            s_nxt.mode = wdata[src_pkg::SC_MODE_LSB +: src_pkg::SC_MODE_W];
            s_nxt.rtc_en = wdata[src_pkg::SC_RTC_EN];
          end
        end
        src_pkg::OFF_PWR_RED: s_nxt.pr = wdata[N_PER-1:0];
        src_pkg::OFF_RST_STATUS: s_nxt.rflags = s_r.rflags & ~wdata[src_pkg::RF_W-1:0];
        src_pkg::OFF_RST_CTRL: begin
          s_nxt.wdt_en = wdata[src_pkg::RC_WDT_EN];
          s_nxt.bod_en = wdata[src_pkg::RC_BOD_EN];
        end
        src_pkg::OFF_INT_STATUS: s_nxt.ists = s_r.ists & ~wdata[src_pkg::EV_W-1:0];
        src_pkg::OFF_INT_MASK: s_nxt.imask = wdata[src_pkg::EV_W-1:0];
        default: ;
      endcase
    end
    // register reads, unmapped reads as zero
    if (rd) begin
      unique case (addr)
        src_pkg::OFF_SLEEP_CTRL: begin
          s_nxt.rdata[src_pkg::SC_MODE_LSB +: src_pkg::SC_MODE_W] = s_r.mode;
          s_nxt.rdata[src_pkg::SC_RTC_EN] = s_r.rtc_en;
        end
        src_pkg::OFF_PWR_RED: s_nxt.rdata = src_pkg::DATA_W'(s_r.pr);
        src_pkg::OFF_RST_STATUS: s_nxt.rdata = src_pkg::DATA_W'(s_r.rflags);
        src_pkg::OFF_RST_CTRL: begin
          s_nxt.rdata[src_pkg::RC_WDT_EN] = s_r.wdt_en;
          s_nxt.rdata[src_pkg::RC_BOD_EN] = s_r.bod_en;
        end
        src_pkg::OFF_INT_STATUS: s_nxt.rdata = src_pkg::DATA_W'(s_r.ists);
        src_pkg::OFF_INT_MASK: s_nxt.rdata = src_pkg::DATA_W'(s_r.imask);
        src_pkg::OFF_SLEEP_STATE: s_nxt.rdata[0] = (s_r.st == ST_SLEEP);
        default: ;
      endcase
    end
    // sleep sequencing
    unique case (s_r.st)
      ST_ACTIVE: begin
        if (sleep_req) begin
          s_nxt.st = ST_SLEEP;
          ev[src_pkg::EV_SLEEP] = 1'b1;
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          s_nxt.st = ST_ACTIVE;
          ev[src_pkg::EV_WAKE] = 1'b1;
        end
      end
    endcase
    // event flags: set wins over clear
    s_nxt.ists = s_nxt.ists | ev;
    // reset flags: set wins over clear, kept over non power-on resets
    s_nxt.rflags = s_nxt.rflags | cause;
    // clock enables from next state
    s_nxt.clk_en = '1;
    if (s_nxt.st == ST_SLEEP) begin
      s_nxt.clk_en.cpu = 1'b0;
      s_nxt.clk_en.nvm = 1'b0;
      unique case (s_nxt.mode)
        src_pkg::MODE_IDLE: ;
        src_pkg::MODE_PDOWN: s_nxt.clk_en = '0;
        src_pkg::MODE_PSAVE: begin
          s_nxt.clk_en = '0;
          s_nxt.clk_en.rtc_src = s_nxt.rtc_en;
          s_nxt.clk_en.rtc = s_nxt.rtc_en;
        end
        src_pkg::MODE_STBY: begin
          s_nxt.clk_en = '0;
          s_nxt.clk_en.sys_src = 1'b1;
        end
        src_pkg::MODE_XSTBY: begin
          s_nxt.clk_en = '0;
          s_nxt.clk_en.sys_src = 1'b1;
          s_nxt.clk_en.rtc_src = s_nxt.rtc_en;
          s_nxt.clk_en.rtc = s_nxt.rtc_en;
        end
        default: s_nxt.clk_en = '0;
      endcase
    end
    s_nxt.per_clk_en = s_nxt.clk_en.per ? ~s_nxt.pr : '0;
    // system reset: registers to initial values, sram is outside
    if (ctl_rst) begin
      s_nxt.st = ST_ACTIVE;
      s_nxt.mode = src_pkg::MODE_RST;
      s_nxt.rtc_en = 1'b0;
      s_nxt.pr = '0;
      s_nxt.ists = '0;
      s_nxt.imask = '0;
      s_nxt.rdata = '0;
      s_nxt.clk_en = '1;
      s_nxt.per_clk_en = '1;
      s_nxt.reset_vec = boot_vec_sel ? BOOT_ADDR : src_pkg::RESET_VEC_DEF;
    end
    // power-on: also flags and reset enables
    if (rst || por_low) begin
      s_nxt.rflags = cause;
      s_nxt.wdt_en = 1'b0;
      s_nxt.bod_en = 1'b0;
    end
    s_nxt.irq = |(s_nxt.ists & s_nxt.imask);
  end
  always_ff @(posedge mclk) begin
    s_r <= s_nxt;
  end
  // ==========================================================
  // outputs
  assign rdata = s_r.rdata;
  assign irq = s_r.irq;
  assign sys_rst = sys_rst_r;
  assign pin_hiz = pin_hiz_r;
  assign clk_en = s_r.clk_en;
  assign per_clk_en = s_r.per_clk_en;
  assign reset_vec = s_r.reset_vec;
  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  a_sleep_entry: assert property (disable iff (rst)
    s_r.st == ST_ACTIVE && sleep_req && !ctl_rst |=> s_r.st == ST_SLEEP && !clk_en.cpu)
    else $error("sleep request not taken");
  a_wake_pdown: assert property (disable iff (rst)
    s_r.st == ST_SLEEP && s_r.mode == src_pkg::MODE_PDOWN && async_wake.twi_match && !ctl_rst
    |=> s_r.st == ST_ACTIVE && clk_en.cpu && s_r.ists[src_pkg::EV_WAKE])
    else $error("address match did not wake from power-down");
  a_pdown_no_wake: assert property (disable iff (rst)
    s_r.st == ST_SLEEP && s_r.mode == src_pkg::MODE_PDOWN && !ctl_rst
    && !async_wake.twi_match && !async_wake.port_async |=> s_r.st == ST_SLEEP)
    else $error("power-down woke on a disallowed source");
  a_idle_clocks: assert property (disable iff (rst)
    s_r.st == ST_SLEEP && s_r.mode == src_pkg::MODE_IDLE
    |-> !clk_en.cpu && !clk_en.nvm && clk_en.per && clk_en.sys_src)
    else $error("idle clock enables wrong");
  a_pdown_clocks: assert property (disable iff (rst)
    s_r.st == ST_SLEEP && s_r.mode == src_pkg::MODE_PDOWN |-> clk_en == '0)
    else $error("power-down left a clock running");
  a_psave_rtc: assert property (disable iff (rst)
    s_r.st == ST_SLEEP && s_r.mode == src_pkg::MODE_PSAVE
    |-> clk_en.rtc == s_r.rtc_en && !clk_en.sys_src && !clk_en.per)
    else $error("power-save rtc clock wrong");
  a_standby_src: assert property (disable iff (rst)
    s_r.st == ST_SLEEP && s_r.mode == src_pkg::MODE_STBY
    |-> clk_en.sys_src && !clk_en.rtc && !clk_en.per && !clk_en.cpu)
    else $error("standby clock enables wrong");
  a_pr_gate: assert property (disable iff (rst)
    s_r.st == ST_ACTIVE && !ctl_rst && $stable(s_r.pr) |-> per_clk_en == ~s_r.pr)
    else $error("power reduction gating wrong");
  a_reset_hold: assert property (disable iff (rst)
    por_low [*2] |-> sys_rst && pin_hiz && s_r.rflags[src_pkg::RF_POR])
    else $error("power-on low did not hold reset");
  a_ext_flag: assert property (disable iff (rst)
    !ext_rst_n && !por_low |=> sys_rst && s_r.rflags[src_pkg::RF_EXT])
    else $error("external reset not seen");
  a_bod_off: assert property (disable iff (rst)
    bod_low && !s_r.bod_en && !por_low && ext_rst_n && !(wdt_expire && s_r.wdt_en)
    |=> !sys_rst)
    else $error("disabled brown-out caused reset");
  a_irq_level: assert property (disable iff (rst)
    ##1 irq == |($past(s_nxt.ists) & $past(s_nxt.imask)))
    else $error("interrupt output does not follow status");
  // ==========================================================
  // wake qualification and clock checks per mode

  a_wake_idle: assert property (disable iff (rst)
    s_r.st == ST_SLEEP && s_r.mode == src_pkg::MODE_IDLE && !ctl_rst && (|per_irq)
    |=> s_r.st == ST_ACTIVE && clk_en.cpu)
    else $error("peripheral interrupt did not wake from idle");

  a_wake_psave_rtc: assert property (disable iff (rst)
    s_r.st == ST_SLEEP && s_r.mode == src_pkg::MODE_PSAVE && !ctl_rst
    && async_wake.rtc_irq && s_r.rtc_en |=> s_r.st == ST_ACTIVE)
    else $error("rtc interrupt did not wake from power-save");

  a_psave_no_rtc: assert property (disable iff (rst)
    s_r.st == ST_SLEEP && s_r.mode == src_pkg::MODE_PSAVE && !ctl_rst && !s_r.rtc_en
    && !async_wake.twi_match && !async_wake.port_async |=> s_r.st == ST_SLEEP)
    else $error("power-save woke with rtc disabled");

  a_stby_no_wake: assert property (disable iff (rst)
    s_r.st == ST_SLEEP && s_r.mode == src_pkg::MODE_STBY && !ctl_rst
    && !async_wake.twi_match && !async_wake.port_async |=> s_r.st == ST_SLEEP)
    else $error("standby woke on a disallowed source");

  a_xstby_clocks: assert property (disable iff (rst)
    s_r.st == ST_SLEEP && s_r.mode == src_pkg::MODE_XSTBY
    |-> clk_en.sys_src && clk_en.rtc == s_r.rtc_en && clk_en.rtc_src == s_r.rtc_en
    && !clk_en.per && !clk_en.cpu)
    else $error("extended standby clock enables wrong");

  a_sleep_flag: assert property (disable iff (rst)
    s_r.st == ST_ACTIVE && sleep_req && !ctl_rst |=> s_r.ists[src_pkg::EV_SLEEP])
    else $error("sleep entry event not flagged");

  a_bad_mode: assert property (disable iff (rst)
    s_r.st == ST_ACTIVE && wr && addr == src_pkg::OFF_SLEEP_CTRL && wdata[src_pkg::SC_GO]
    && wdata[src_pkg::SC_MODE_LSB +: src_pkg::SC_MODE_W] > src_pkg::MODE_XSTBY && !ctl_rst
    |=> s_r.st == ST_ACTIVE)
    else $error("illegal sleep mode was entered");

  // ==========================================================
  // reset source checks

  a_src_async: assert property (disable iff (rst)
    src_any |-> sys_rst && pin_hiz)
    else $error("reset source did not assert reset");

  a_ext_hiz: assert property (disable iff (rst)
    !ext_rst_n |-> sys_rst && pin_hiz)
    else $error("external reset did not tristate pins");

  a_wdt_reset: assert property (disable iff (rst)
    wdt_expire && s_r.wdt_en |-> sys_rst)
    else $error("enabled watchdog expiry did not reset");

  a_bod_reset: assert property (disable iff (rst)
    bod_low && s_r.bod_en |-> sys_rst)
    else $error("enabled brown-out did not reset");

  a_por_flags: assert property (disable iff (rst)
    por_low |=> s_r.rflags[src_pkg::RF_POR] && !s_r.wdt_en && !s_r.bod_en)
    else $error("power-on did not clear enables");

  a_flag_keep: assert property (disable iff (rst)
    ctl_rst && !por_low && s_r.rflags[src_pkg::RF_EXT]
    && !(wr && addr == src_pkg::OFF_RST_STATUS) |=> s_r.rflags[src_pkg::RF_EXT])
    else $error("reset flag lost over a non power-on reset");

  a_reset_regs: assert property (disable iff (rst)
    ctl_rst |=> s_r.st == ST_ACTIVE && s_r.pr == '0 && s_r.imask == '0 && clk_en == '1)
    else $error("registers not returned to initial values");

  a_boot_vec: assert property (@(posedge mclk)
    ctl_rst && boot_vec_sel |=> reset_vec == BOOT_ADDR)
    else $error("reset vector not moved to boot start");

  a_rdata_zero: assert property (disable iff (rst)
    !rd |=> rdata == '0)
    else $error("read data not zero outside a read");
endmodule // sleep_reset_ctrl
`default_nettype wire

// ### bench/test_sleep_and_reset_control.sv
// self-checking bench for the sleep and reset controller
`timescale 1ns/10ps
`default_nettype none
module test_sleep_and_reset_control;
  localparam logic [15:0] BOOT = 16'h2A00;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [7:0] per_irq = 8'h00;
  src_pkg::async_wake_t async_wake = '0;
  logic por_low = 1'b0;
  logic ext_rst_n = 1'b1;
  logic wdt_expire = 1'b0;
  logic bod_low = 1'b0;
  logic boot_vec_sel = 1'b0;
  logic irq;
  logic sys_rst;
  logic pin_hiz;
  src_pkg::clk_en_t clk_en;
  logic [7:0] per_clk_en;
  logic [15:0] reset_vec;
  logic [31:0] v = 32'hFA50;
  logic [31:0] e;
  int fails = 0;
  int n_tests = 0;

  sleep_reset_ctrl #(.N_PER(8), .BOOT_ADDR(BOOT)) dut (.mclk(mclk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .per_irq(per_irq), .async_wake(async_wake),
    .por_low(por_low), .ext_rst_n(ext_rst_n), .wdt_expire(wdt_expire), .bod_low(bod_low),
    .boot_vec_sel(boot_vec_sel), .irq(irq), .sys_rst(sys_rst), .pin_hiz(pin_hiz),
    .clk_en(clk_en), .per_clk_en(per_clk_en), .reset_vec(reset_vec));

  always #5 mclk = ~mclk;

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [5:0] exp_clk(input logic [2:0] m, input logic rt);
    case (m)
      src_pkg::MODE_IDLE: exp_clk = 6'h0F;
      src_pkg::MODE_STBY: exp_clk = 6'h04;
      src_pkg::MODE_XSTBY: exp_clk = {4'h1, rt, rt};
      src_pkg::MODE_PSAVE: exp_clk = {4'h0, rt, rt};
      default: exp_clk = 6'h00;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // one sleep entry, refused wakes except in idle, then an allowed wake
  task automatic sleep_cycle(input logic [2:0] m, input logic rt);
    logic rtc_ok;
    rtc_ok = rt && (m == src_pkg::MODE_PSAVE || m == src_pkg::MODE_XSTBY);
    wr_reg(src_pkg::OFF_INT_MASK, rt ? 32'h1 : 32'h2);
    wr_reg(src_pkg::OFF_SLEEP_CTRL, {27'h0, 1'b1, rt, m});
    repeat (2) @(posedge mclk);
    #1 chk({26'h0, clk_en}, {26'h0, exp_clk(m, rt)});
    chk({31'h0, irq}, {31'h0, !rt});
    v = lfsr(v);
    if (m != src_pkg::MODE_IDLE) begin
      @(posedge mclk);
      per_irq <= v[7:0] | 8'h01;
      async_wake.rtc_irq <= !rtc_ok;
      repeat (3) @(posedge mclk);
      per_irq <= 8'h00;
      async_wake <= '0;
      rd_chk(src_pkg::OFF_SLEEP_STATE, 32'h1);
    end
    @(posedge mclk);
    if (m == src_pkg::MODE_IDLE) per_irq <= v[7:0] | 8'h01;
    else if (rtc_ok) async_wake.rtc_irq <= 1'b1;
    else if (v[8]) async_wake.twi_match <= 1'b1;
    else async_wake.port_async <= 1'b1;
    @(posedge mclk);
    per_irq <= 8'h00;
    async_wake <= '0;
    repeat (2) @(posedge mclk);
    #1 chk({26'h0, clk_en}, 32'h3F);
    rd_chk(src_pkg::OFF_SLEEP_STATE, 32'h0);
    rd_chk(src_pkg::OFF_INT_STATUS, 32'h3);
    wr_reg(src_pkg::OFF_INT_STATUS, 32'h3);
    repeat (2) @(posedge mclk);
    #1 chk({31'h0, irq}, 32'h0);
  endtask

  // reset source pulse: 0 ext, 1 watchdog, 2 brown-out, 3 power-on
  task automatic hit(input int k, input logic fire);
    @(posedge mclk);
    case (k)
      0: ext_rst_n <= 1'b0;
      1: wdt_expire <= 1'b1;
      2: bod_low <= 1'b1;
      default: por_low <= 1'b1;
    endcase
    #1 chk({30'h0, sys_rst, pin_hiz}, fire ? 32'h3 : 32'h0);
    repeat (2) @(posedge mclk);
    ext_rst_n <= 1'b1;
    wdt_expire <= 1'b0;
    bod_low <= 1'b0;
    por_low <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk({16'h0, reset_vec}, 32'h0);
    rd_chk(src_pkg::OFF_PWR_RED, 32'h0);
    rd_chk(src_pkg::OFF_INT_MASK, 32'h0);
    rd_chk(8'hFC, 32'h0);
    repeat (4) begin
      v = lfsr(v);
      wr_reg(src_pkg::OFF_PWR_RED, {24'h0, v[7:0]});
      repeat (2) @(posedge mclk);
      #1 chk({24'h0, per_clk_en}, {24'h0, ~v[7:0]});
    end
    wr_reg(src_pkg::OFF_PWR_RED, 32'h0);
    for (int m = 0; m < 5; m++) begin
      sleep_cycle(m[2:0], 1'b0);
      sleep_cycle(m[2:0], 1'b1);
    end
    wr_reg(src_pkg::OFF_SLEEP_CTRL, 32'h15);
    rd_chk(src_pkg::OFF_SLEEP_STATE, 32'h0);
    hit(1, 1'b0);
    hit(2, 1'b0);
    rd_chk(src_pkg::OFF_RST_STATUS, 32'h0);
    wr_reg(src_pkg::OFF_RST_CTRL, 32'h3);
    wr_reg(src_pkg::OFF_SLEEP_CTRL, 32'h11);
    e = 32'h0;
    for (int k = 0; k < 3; k++) begin
      hit(k, 1'b1);
      e = e | (32'h1 << (k + 1));
      rd_chk(src_pkg::OFF_RST_STATUS, e);
    end
    rd_chk(src_pkg::OFF_SLEEP_STATE, 32'h0);
    rd_chk(src_pkg::OFF_RST_CTRL, 32'h3);
    wr_reg(src_pkg::OFF_RST_STATUS, 32'h2);
    rd_chk(src_pkg::OFF_RST_STATUS, 32'hC);
    hit(3, 1'b1);
    rd_chk(src_pkg::OFF_RST_STATUS, 32'h1);
    rd_chk(src_pkg::OFF_RST_CTRL, 32'h0);
    hit(2, 1'b0);
    @(posedge mclk);
    boot_vec_sel <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk({16'h0, reset_vec}, {16'h0, BOOT});
    give_verdict;
  end

  // hang guard
  initial begin
    #100000;
    fails++;
    give_verdict;
  end
endmodule // test_sleep_and_reset_control
`default_nettype wire
